// ### design/ctm_top.sv
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "ctm_cfg.svh"
// Behaviour
// - pause bit freezes counter, zero runs
// - pause keeps value, resumes counting from it
// - clock select picks the count clock
// - on rising clears counter, falling keeps value
// - counter off: no counting, dividers stopped
// - on rising loads pin initial level
// - period value matched against counter bits 9..7
// - zero period value: counter runs to overflow
// - mode field: compare, PWM, timer
// - compare mode pin action on A match
// - PWM mode: inactive, active or waveform
// - same requested level gives no visible change
// - level bit: initial level or PWM polarity
// - invert bit inverts the output pin
// - swap bit exchanges duty and period roles
// - clear source selects A or P/overflow
// - PWM mode ignores clear source, uses swap
// - timer mode leaves output pin undriven
// - counter read only, compare A read/write pair
// - low byte goes through an 8-bit buffer
// - clear-on-A outside PWM: no P flag
// - compare mode pin follows only A matches
// - duty at or above period: always active
module ctm_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        hi_clk_en,
  input  wire logic        sub_clk_en,
  input  wire logic        external_count_input,
  output logic             timer_output_pin,
  output logic             timer_output_pin_inverse,
  output logic             timer_output_pin_oe,
  output logic             compare_a_flag,
  output logic             compare_p_flag
);
  // bus side state
  logic        dp_q;       // data phase pending
  logic        dw_q;       // pending access is a write
  logic [7:0]  da_q;       // pending byte address
  logic        rdy_q;      // hreadyout
  logic [31:0] rdata_q;    // read data
  // control and data registers
  logic [7:0]  c0_q;       // timer_control_zero
  logic [7:0]  c1_q;       // timer_control_one
  logic [9:0]  cnt_q;      // counter
  logic [9:0]  cmpa_q;     // compare_a_value
  logic [7:0]  cnt_buf_q;  // counter low byte buffer
  logic [7:0]  cmpa_buf_q; // compare low byte buffer
  logic        on_prev_q;  // counter_on one cycle ago
  logic        out_q;      // internal output level before invert
  logic        pin_q;
  logic        pinb_q;
  logic        oe_q;
  logic        flag_a_q;
  logic        flag_p_q;

  // decode of the register fields
  logic        count_pause;
  logic [2:0]  count_clock_select;
  logic        counter_on;
  logic [2:0]  period_compare_value;
  ctm_pkg::ctm_mode_e operating_mode_select;
  ctm_pkg::ctm_io_e   pin_action_select;
  logic        output_level_control;
  logic        output_invert;
  logic        duty_period_swap;
  logic        clear_source_select;

  assign count_pause           = c0_q[`CTM_C0_PAU];
  assign count_clock_select    = c0_q[`CTM_C0_CK_H:`CTM_C0_CK_L];
  assign counter_on            = c0_q[`CTM_C0_ON];
  assign period_compare_value  = c0_q[`CTM_C0_RP_H:`CTM_C0_RP_L];
  assign operating_mode_select = ctm_pkg::ctm_mode_e'(c1_q[`CTM_C1_M_H:`CTM_C1_M_L]);
  assign pin_action_select     = ctm_pkg::ctm_io_e'(c1_q[`CTM_C1_IO_H:`CTM_C1_IO_L]);
  assign output_level_control  = c1_q[`CTM_C1_OC];
  assign output_invert         = c1_q[`CTM_C1_POL];
  assign duty_period_swap      = c1_q[`CTM_C1_DPX];
  assign clear_source_select   = c1_q[`CTM_C1_CCLR];

  // mode flags; the undefined code behaves as timer mode
  logic mode_cmp;
  logic mode_pwm;
  logic pin_used;
  assign mode_cmp = (operating_mode_select == ctm_pkg::CTM_MODE_CMP);
  assign mode_pwm = (operating_mode_select == ctm_pkg::CTM_MODE_PWM);
  assign pin_used = mode_cmp | mode_pwm;

  // bus decode
  logic addr_take;
  logic wr_do;
  logic rd_do;
  assign addr_take = hsel & hready & htrans[1];
  assign wr_do     = dp_q & dw_q;
  assign rd_do     = dp_q & ~dw_q & ~rdy_q;

  logic wr_c0;
  logic wr_c1;
  logic wr_al;
  logic wr_ah;
  logic rd_dh;
  logic rd_ah;
  assign wr_c0 = wr_do & (da_q == `CTM_ADR_C0);
  assign wr_c1 = wr_do & (da_q == `CTM_ADR_C1);
  assign wr_al = wr_do & (da_q == `CTM_ADR_AL);
  assign wr_ah = wr_do & (da_q == `CTM_ADR_AH);
  assign rd_dh = rd_do & (da_q == `CTM_ADR_DH);
  assign rd_ah = rd_do & (da_q == `CTM_ADR_AH);

  // read mux; low bytes come from the buffers
  logic [31:0] rd_mux;
  assign rd_mux = (da_q == `CTM_ADR_C0) ? {24'h000000, c0_q} :
                  (da_q == `CTM_ADR_C1) ? {24'h000000, c1_q} :
                  (da_q == `CTM_ADR_DL) ? {24'h000000, cnt_buf_q} :
                  (da_q == `CTM_ADR_DH) ? {30'h00000000, cnt_q[9:8]} :
                  (da_q == `CTM_ADR_AL) ? {24'h000000, cmpa_buf_q} :
                  (da_q == `CTM_ADR_AH) ? {30'h00000000, cmpa_q[9:8]} :
                  32'h00000000;

  // bus handshake: writes take no wait, reads take one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_q  <= 1'b0;
      dw_q  <= 1'b0;
      da_q  <= 8'h00;
      rdy_q <= 1'b1;
    end else begin
      dp_q  <= addr_take | (dp_q & ~rdy_q);
      rdy_q <= ~(addr_take & ~hwrite);
      if (addr_take) begin
        dw_q <= hwrite;
        da_q <= haddr[7:0];
      end
    end
  end

  // read data register, held between reads
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h00000000;
    end else if (rd_do) begin
      rdata_q <= rd_mux;
    end
  end

  // control registers, written whole
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      c0_q      <= `CTM_CTL_RST;
      c1_q      <= `CTM_CTL_RST;
      on_prev_q <= 1'b0;
    end else begin
      on_prev_q <= counter_on;
      if (wr_c0) begin
        c0_q <= hwdata[7:0];
      end
      if (wr_c1) begin
        c1_q <= hwdata[7:0];
      end
    end
  end

  // byte pair buffers and compare register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_buf_q  <= 8'h00;
      cmpa_buf_q <= 8'h00;
      cmpa_q     <= `CTM_CNT_RST;
    end else begin
      if (rd_dh) begin
        cnt_buf_q <= cnt_q[7:0];
      end
      // low write lands in the buffer only
      if (wr_al) begin
        cmpa_buf_q <= hwdata[7:0];
      end else if (rd_ah) begin
        cmpa_buf_q <= cmpa_q[7:0];
      end
      // high write commits both bytes at once
      if (wr_ah) begin
        cmpa_q <= {hwdata[1:0], cmpa_buf_q};
      end
    end
  end

  // count clock
  logic ext_rise;
  logic ext_fall;
  logic tick;
  logic run;
  assign run = counter_on & ~count_pause;

  ctm_edge u_edge (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin_in  (external_count_input),
    .rise    (ext_rise),
    .fall    (ext_fall)
  );

  ctm_prescale u_prescale (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .run      (run),
    .off      (~counter_on),
    .sel      (count_clock_select),
    .hi_en    (hi_clk_en),
    .sub_en   (sub_clk_en),
    .ext_rise (ext_rise),
    .ext_fall (ext_fall),
    .tick     (tick)
  );

  // comparators look at the value the counter is about to take
  logic        on_rise;
  logic [10:0] nxt;
  logic        a_hit;
  logic        p_hit;
  logic        clr;
  logic        p_flag_d;
  assign on_rise = counter_on & ~on_prev_q;
  assign nxt     = {1'b0, cnt_q} + 11'h001;
  // zero compare A never matches; the counter wraps instead
  assign a_hit   = tick & (cmpa_q != 10'h000) & (nxt[9:0] == cmpa_q);
  // top three bits against the period value, zero means overflow
  assign p_hit   = tick & ((period_compare_value == 3'h0) ? nxt[10] :
                   ((nxt[9:7] == period_compare_value) & (nxt[6:0] == 7'h00)));
  // clear source; PWM uses the swap bit instead
  assign clr     = mode_pwm ? (duty_period_swap ? a_hit : p_hit) :
                   (clear_source_select ? a_hit : p_hit);
  // clear-on-A outside PWM suppresses the P flag
  assign p_flag_d = p_hit & (mode_pwm | ~clear_source_select);

  // counter; on rising wins over a tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= `CTM_CNT_RST;
    end else if (on_rise) begin
      cnt_q <= `CTM_CNT_RST;
    end else if (tick) begin
      cnt_q <= clr ? `CTM_CNT_RST : nxt[9:0];
    end
  end

  // PWM duty and period spans
  logic [10:0] rp_span;
  logic [10:0] period;
  logic [10:0] duty;
  logic        pwm_act;
  assign rp_span = (period_compare_value == 3'h0) ? `CTM_P_FULL :
                   {1'b0, period_compare_value, 7'h00};
  assign period  = duty_period_swap ? {1'b0, cmpa_q} : rp_span;
  assign duty    = duty_period_swap ? rp_span : {1'b0, cmpa_q};
  // full duty when duty reaches the period
  assign pwm_act = (duty >= period) | ({1'b0, cnt_q} < duty);

  // output level; the level bit is initial level or active level
  logic out_d;
  always_comb begin
    out_d = out_q;
    if (on_rise & pin_used) begin
      out_d = output_level_control;
    end else if (mode_cmp & a_hit) begin
      // only A matches move the pin; equal level shows nothing
      unique case (pin_action_select)
        ctm_pkg::CTM_IO_00: out_d = out_q;
        ctm_pkg::CTM_IO_01: out_d = 1'b0;
        ctm_pkg::CTM_IO_10: out_d = 1'b1;
        ctm_pkg::CTM_IO_11: out_d = ~out_q;
      endcase
    end else if (mode_pwm) begin
      // changing this while running glitches the pin; software stops first
      unique case (pin_action_select)
        ctm_pkg::CTM_IO_00: out_d = ~output_level_control;
        ctm_pkg::CTM_IO_01: out_d = output_level_control;
        ctm_pkg::CTM_IO_10: out_d = pwm_act ? output_level_control
                                            : ~output_level_control;
        ctm_pkg::CTM_IO_11: out_d = out_q;
      endcase
    end
  end

  // pins and flags, all registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_q    <= 1'b0;
      pin_q    <= 1'b0;
      pinb_q   <= 1'b1;
      oe_q     <= 1'b0;
      flag_a_q <= 1'b0;
      flag_p_q <= 1'b0;
    end else begin
      out_q    <= out_d;
      // timer mode releases the pin
      oe_q     <= pin_used;
      pin_q    <= pin_used & (out_q ^ output_invert);
      pinb_q   <= ~(pin_used & (out_q ^ output_invert));
      flag_a_q <= a_hit;
      flag_p_q <= p_flag_d;
    end
  end

  assign hreadyout                = rdy_q;
  assign hrdata                   = rdata_q;
  assign hresp                    = 1'b0;
  assign timer_output_pin         = pin_q;
  assign timer_output_pin_inverse = pinb_q;
  assign timer_output_pin_oe      = oe_q;
  assign compare_a_flag           = flag_a_q;
  assign compare_p_flag           = flag_p_q;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_PAUSE_HOLD: assert property (
    (count_pause & !on_rise) |=> (cnt_q == $past(cnt_q)))
    else $error("counter moved during pause");
  AST_ON_CLEAR: assert property (
    on_rise |=> (cnt_q == 10'h000))
    else $error("counter not cleared on enable");
  AST_OFF_HOLD: assert property (
    !counter_on |=> $stable(cnt_q))
    else $error("counter moved while off");
  AST_INIT_LEVEL: assert property (
    (on_rise & pin_used) |=> (out_q == $past(output_level_control)))
    else $error("initial level not loaded");
  AST_NO_P_FLAG: assert property (
    (!mode_pwm & clear_source_select) |=> !compare_p_flag)
    else $error("period flag raised with clear on A");
  AST_PIN_IDLE: assert property (
    !pin_used |=> !timer_output_pin_oe)
    else $error("pin driven in timer mode");
  AST_INVERSE: assert property (
    timer_output_pin_inverse == !timer_output_pin)
    else $error("inverse pin mismatch");
  AST_PIN_POL: assert property (
    pin_used |=> (timer_output_pin == $past(out_q ^ output_invert)))
    else $error("pin polarity wrong");
  AST_FULL_DUTY: assert property (
    (mode_pwm & pin_action_select == ctm_pkg::CTM_IO_10 & duty >= period & !on_rise)
    |=> (out_q == $past(output_level_control)))
    else $error("full duty not active");
  AST_CLEAR_A: assert property (
    (mode_cmp & clear_source_select & a_hit & !on_rise) |=> (cnt_q == 10'h000))
    else $error("A match did not clear");
  AST_TOGGLE: assert property (
    (mode_cmp & a_hit & pin_action_select == ctm_pkg::CTM_IO_11 & !on_rise)
    |=> (out_q != $past(out_q)))
    else $error("toggle missed");
  AST_P_WRAP: assert property (
    (tick & !on_rise & period_compare_value == 3'h0 & cnt_q == 10'h3ff)
    |=> (cnt_q == 10'h000) && (compare_p_flag == $past(mode_pwm || !clear_source_select)))
    else $error("overflow not handled");
endmodule // ctm_top

// ### common/ctm_cfg.svh
`ifndef CTM_CFG_SVH
`define CTM_CFG_SVH
// register byte offsets on the bus
`define CTM_ADR_C0   8'h00
`define CTM_ADR_C1   8'h04
`define CTM_ADR_DL   8'h08
`define CTM_ADR_DH   8'h0c
`define CTM_ADR_AL   8'h10
`define CTM_ADR_AH   8'h14
// control zero fields
`define CTM_C0_PAU   7
`define CTM_C0_CK_H  6
`define CTM_C0_CK_L  4
`define CTM_C0_ON    3
`define CTM_C0_RP_H  2
`define CTM_C0_RP_L  0
// control one fields
`define CTM_C1_M_H   7
`define CTM_C1_M_L   6
`define CTM_C1_IO_H  5
`define CTM_C1_IO_L  4
`define CTM_C1_OC    3
`define CTM_C1_POL   2
`define CTM_C1_DPX   1
`define CTM_C1_CCLR  0
// reset values
`define CTM_CTL_RST  8'h00
`define CTM_CNT_RST  10'h000
// prescaler terminal counts
`define CTM_DIV_SYS4 2'h3
`define CTM_DIV_H16  4'hf
`define CTM_DIV_H64  6'h3f
// period span with zero period value: 1024 clocks
`define CTM_P_FULL   11'h400
`endif

// ### common/ctm_pkg.sv
package ctm_pkg;
  // operating mode field
  typedef enum logic [1:0] {
    CTM_MODE_CMP   = 2'h0,
    CTM_MODE_UNDEF = 2'h1,
    CTM_MODE_PWM   = 2'h2,
    CTM_MODE_TMR   = 2'h3
  } ctm_mode_e;
  // pin action field
  typedef enum logic [1:0] {
    CTM_IO_00 = 2'h0,
    CTM_IO_01 = 2'h1,
    CTM_IO_10 = 2'h2,
    CTM_IO_11 = 2'h3
  } ctm_io_e;
  // count clock select field
  typedef enum logic [2:0] {
    CTM_CK_SYS4 = 3'h0,
    CTM_CK_SYS  = 3'h1,
    CTM_CK_H16  = 3'h2,
    CTM_CK_H64  = 3'h3,
    CTM_CK_SUBA = 3'h4,
    CTM_CK_SUBB = 3'h5,
    CTM_CK_EXTR = 3'h6,
    CTM_CK_EXTF = 3'h7
  } ctm_clk_e;
endpackage

// ### design/ctm_edge.sv
`timescale 1ns/1ps
// synchroniser and edge detector for the external count pin
module ctm_edge (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic pin_in,
  output logic      rise,
  output logic      fall
);
  logic s1_q;  // first stage, read only by s2_q
  logic s2_q;  // settled level
  logic s3_q;  // previous settled level

  // three flops: two to settle, one for the edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // edges seen only past the settled stage
  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;
endmodule // ctm_edge

// ### design/ctm_prescale.sv
`timescale 1ns/1ps
`include "ctm_cfg.svh"
// count clock selection; every rate is an enable pulse on hclk
module ctm_prescale (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       run,
  input  wire logic       off,
  input  wire logic [2:0] sel,
  input  wire logic       hi_en,
  input  wire logic       sub_en,
  input  wire logic       ext_rise,
  input  wire logic       ext_fall,
  output logic            tick
);
  logic [1:0] sys_cnt_q;  // system clock divide by four
  logic [5:0] hi_cnt_q;   // high clock divide by 16 and 64
  logic       sys_wrap;
  logic       h16_wrap;
  logic       h64_wrap;

  assign sys_wrap = (sys_cnt_q == `CTM_DIV_SYS4);
  assign h16_wrap = hi_en & (hi_cnt_q[3:0] == `CTM_DIV_H16);
  assign h64_wrap = hi_en & (hi_cnt_q == `CTM_DIV_H64);

  // dividers held cleared while the timer is off, to save power
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sys_cnt_q <= 2'h0;
      hi_cnt_q  <= 6'h00;
    end else if (off) begin
      sys_cnt_q <= 2'h0;
      hi_cnt_q  <= 6'h00;
    end else if (run) begin
      sys_cnt_q <= sys_cnt_q + 2'h1;
      if (hi_en) begin
        hi_cnt_q <= hi_cnt_q + 6'h01;
      end
    end
  end

  // source select, gated by run
  always_comb begin
    unique case (ctm_pkg::ctm_clk_e'(sel))
      ctm_pkg::CTM_CK_SYS4: tick = run & sys_wrap;
      ctm_pkg::CTM_CK_SYS:  tick = run;
      ctm_pkg::CTM_CK_H16:  tick = run & h16_wrap;
      ctm_pkg::CTM_CK_H64:  tick = run & h64_wrap;
      ctm_pkg::CTM_CK_SUBA: tick = run & sub_en;
      ctm_pkg::CTM_CK_SUBB: tick = run & sub_en;
      ctm_pkg::CTM_CK_EXTR: tick = run & ext_rise;
      ctm_pkg::CTM_CK_EXTF: tick = run & ext_fall;
    endcase
  end
endmodule // ctm_prescale

// ### tb/ctm_tb.sv
`timescale 1ns/1ps
`include "ctm_cfg.svh"
// bench for the compact timer: bus traffic, count spans, pin levels, pwm duty
module tb;
  logic        hclk;      // 20 MHz bus clock
  logic        hresetn;   // async reset, low active
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;    // looped back from the one slave
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        hi_en;     // high clock enable pulses
  logic        sub_en;    // sub clock enable pulses
  logic        ext;       // external count pin
  logic        pin;
  logic        pin_n;
  logic        pin_oe;
  logic        fa;        // comparator a flag
  logic        fp;        // comparator p flag
  int          failures;
  int          checks;

  assign hready = hreadyout;

  ctm_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .hi_clk_en(hi_en),
    .sub_clk_en(sub_en), .external_count_input(ext), .timer_output_pin(pin),
    .timer_output_pin_inverse(pin_n), .timer_output_pin_oe(pin_oe),
    .compare_a_flag(fa), .compare_p_flag(fp));

  // free running clock
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // one comparison, counted
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got %0h expected %0h", $time, g, e);
    end
  endtask

  // single ahb transfer; waits on hready, no assumed latency
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata[7:0];
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    bus(1'b0, a, 8'h00, q);
  endtask

  // high byte first so the low byte is latched
  task automatic rcnt(output logic [9:0] v);
    logic [7:0] h;
    logic [7:0] l;
    rd(`CTM_ADR_DH, h);
    rd(`CTM_ADR_DL, l);
    v = {h[1:0], l};
  endtask

  // low byte into the buffer, high byte commits
  task automatic wa(input logic [9:0] v);
    wr(`CTM_ADR_AL, v[7:0]);
    wr(`CTM_ADR_AH, {6'h00, v[9:8]});
  endtask

  // mode changes only while switched off
  task automatic cfg(input logic [7:0] c1, input logic [7:0] c0);
    wr(`CTM_ADR_C0, 8'h00);
    wr(`CTM_ADR_C1, c1);
    wr(`CTM_ADR_C0, c0);
  endtask

  // cycles up to the next flag pulse, bounded
  task automatic wfl(input bit a, output int n);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (((a ? fa : fp) !== 1'b1) && (n < 20000));
    // a flag that never comes counts as a mismatch
    if (n >= 20000) begin
      failures++;
      $display("[FAIL] t=%0t flag wait timed out", $time);
    end
  endtask

  // reset values, read-only counter, unmapped place, byte pairing
  task automatic t_regs;
    logic [7:0] ad [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
    logic [7:0] q;
    wr(`CTM_ADR_DL, 8'hff);
    wr(`CTM_ADR_DH, 8'h03);
    wr(8'h20, 8'hff);
    foreach (ad[i]) begin
      rd(ad[i], q);
      chk(q, 8'h00);
      chk(hresp, 1'b0);
    end
    wr(`CTM_ADR_C1, 8'ha5);
    rd(`CTM_ADR_C1, q);
    chk(q, 8'ha5);
    wa(10'h33c);
    rd(`CTM_ADR_AH, q);
    chk(q, 8'h03);
    rd(`CTM_ADR_AL, q);
    chk(q, 8'h3c);
    $display("test regs done");
  endtask

  // match spans for the six internal clock sources and for period values 1, 0 and 7
  task automatic t_span;
    logic [7:0] c0 [8] = '{8'h09, 8'h19, 8'h29, 8'h39, 8'h49, 8'h59, 8'h18, 8'h1f};
    int         sp [8] = '{512, 128, 2048, 8192, 128, 128, 1024, 896};
    int         n;
    int         k;
    wa(10'h000);
    foreach (c0[i]) begin
      cfg(8'h20, c0[i]);
      wfl(1'b0, n);
      wfl(1'b0, n);
      chk(n, sp[i]);
      chk(pin, 1'b0);
    end
    // clear on a; p lies below a yet never flags
    wa(10'h12c);
    cfg(8'h01, 8'h19);
    wfl(1'b1, n);
    wfl(1'b1, n);
    chk(n, 300);
    k = 0;
    repeat (700) begin
      @(posedge hclk);
      k += (fp === 1'b1);
    end
    chk(k, 0);
    $display("test span done");
  endtask

  // pause, switch off and on again
  task automatic t_pause;
    logic [9:0] a;
    logic [9:0] b;
    cfg(8'hc0, 8'h18);
    wr(`CTM_ADR_C0, 8'h98);
    rcnt(a);
    repeat (20) @(posedge hclk);
    rcnt(b);
    chk(b, a);
    wr(`CTM_ADR_C0, 8'h18);
    rcnt(b);
    chk((b > a) && (b < a + 10'd40), 1'b1);
    wr(`CTM_ADR_C0, 8'h10);
    rcnt(a);
    repeat (20) @(posedge hclk);
    rcnt(b);
    chk(b, a);
    wr(`CTM_ADR_C0, 8'h18);
    rcnt(b);
    chk((b < a) && (b < 10'd20), 1'b1);
    $display("test pause done");
  endtask

  // pin actions in compare mode, then timer mode releases the pin
  task automatic t_pin;
    logic [7:0] c1 [7] = '{8'h01, 8'h11, 8'h21, 8'h31, 8'h29, 8'h25, 8'h39};
    logic       i0 [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    logic       i1 [7] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    int         n;
    wa(10'd20);
    foreach (c1[i]) begin
      cfg(c1[i], 8'h18);
      repeat (3) @(posedge hclk);
      chk(pin, i0[i]);
      wfl(1'b1, n);
      repeat (3) @(posedge hclk);
      chk(pin, i1[i]);
      chk(pin_n, !i1[i]);
      chk(pin_oe, 1'b1);
    end
    cfg(8'hc1, 8'h18);
    repeat (3) @(posedge hclk);
    chk(pin_oe, 1'b0);
    wfl(1'b1, n);
    chk(n <= 30, 1'b1);
    // undefined mode code releases the pin as timer mode does
    cfg(8'h41, 8'h18);
    repeat (3) @(posedge hclk);
    chk(pin_oe, 1'b0);
    $display("test pin done");
  endtask

  // high time over one whole pwm period
  task automatic t_pwm;
    logic [9:0] av [7] = '{10'd32, 10'd32, 10'd200, 10'd32, 10'd32, 10'd200, 10'd32};
    logic [7:0] c1 [7] = '{8'ha9, 8'ha1, 8'ha8, 8'h89, 8'h99, 8'haa, 8'had};
    int         wn [7] = '{128, 128, 128, 128, 128, 200, 128};
    int         ex [7] = '{32, 96, 128, 0, 128, 128, 96};
    int         h;
    foreach (av[i]) begin
      wa(av[i]);
      cfg(c1[i], 8'h19);
      repeat (450) @(posedge hclk);
      h = 0;
      repeat (wn[i]) begin
        @(posedge hclk);
        h += (pin === 1'b1);
      end
      chk(h, ex[i]);
    end
    $display("test pwm done");
  endtask

  // external pin on both edge selections
  task automatic t_ext;
    logic [7:0] c0 [2] = '{8'h68, 8'h78};
    logic [9:0] v;
    foreach (c0[i]) begin
      cfg(8'hc0, c0[i]);
      repeat (5) begin
        @(posedge hclk);
        ext <= 1'b1;
        repeat (4) @(posedge hclk);
        ext <= 1'b0;
        repeat (3) @(posedge hclk);
      end
      repeat (6) @(posedge hclk);
      rcnt(v);
      chk(v, 10'd5);
    end
    $display("test ext done");
  endtask

  // single place where the run ends
  task automatic test_done;
    $display("checks %0d failures %0d", checks, failures);
    if ((failures == 0) && (checks > 0)) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    hresetn  = 1'b0;
    hsel     = 1'b0;
    haddr    = 32'h00000000;
    htrans   = 2'h0;
    hwrite   = 1'b0;
    hsize    = 3'h2;
    hwdata   = 32'h00000000;
    hi_en    = 1'b1;
    sub_en   = 1'b1;
    ext      = 1'b0;
    failures = 0;
    checks   = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_span;
    t_pause;
    t_pin;
    t_pwm;
    t_ext;
    test_done;
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (90000) @(posedge hclk);
    failures++;
    test_done;
  end
endmodule // tb
